// ---- synth_divider_config_port.sv ----
`timescale 1ns/1ps
// Purpose: configuration logic of the clock synthesizer with a digital stand-in for the vco
// Assumes: every pin is synchronous to core_clk; one core_clk cycle is one vco half period
// Notes: divider chains count ticks; in bypass a tick is any s_clock change
module synth_divider_config_port
  import synth_cfg_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic crystal_reference,
  synth_cfg_if.device link
);

  logic            p_load_prev_r;
  logic            s_clock_prev_r;
  logic            s_load_prev_r;
  logic            ref_prev_r;
  logic [SR_W-1:0] shift_r;
  logic [M_W-1:0]  m_r;
  logic [N_W-1:0]  n_r;
  logic [T_W-1:0]  t_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic [M_W-1:0]  fb_cnt_r;
  logic            fb_pulse_r;
  logic            synth_r;
  logic            synth_nxt;
  logic            byp_half_r;
  logic [DIV_W-1:0] ref_cnt_r;
  logic [1:0]      syn4_cnt_r;
  logic            probe_r;
  logic            probe_nxt;
  logic            p_load_rise;
  logic            s_clock_rise;
  logic            s_clock_edge;
  logic            s_load_fall;
  logic            bypass;
  logic            tick;
  logic            vco_rise;
  logic            synth_rise;

  assign p_load_rise  = link.p_load & ~p_load_prev_r;
  assign s_clock_rise = link.s_clock & ~s_clock_prev_r;
  assign s_clock_edge = link.s_clock ^ s_clock_prev_r;
  assign s_load_fall  = ~link.s_load & s_load_prev_r;
  assign bypass       = (t_r == PROBE_BYPASS);
  // in bypass both s_clock edges advance the chain, so post /1 equals s_clock
  assign tick         = bypass ? s_clock_edge : 1'b1;
  assign vco_rise     = tick & ~div_cnt_r[0];
  assign synth_rise   = synth_nxt & ~synth_r;

  // link pin history; reset values match the idle pin levels so no false edge follows reset
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      p_load_prev_r  <= 1'b0;
      s_clock_prev_r <= 1'b0;
      s_load_prev_r  <= 1'b0;
    end else begin
      p_load_prev_r  <= link.p_load;
      s_clock_prev_r <= link.s_clock;
      s_load_prev_r  <= link.s_load;
    end
  end

  // reference history; a high level at release may count as one edge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ref_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= crystal_reference;
    end
  end

  // serial shift register, fields land msb first at the top end
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      shift_r <= CFG_RESET;
    end else if (link.p_load && s_clock_rise) begin
      shift_r <= {shift_r[SR_W-2:0], link.s_data};
    end
  end

  // divide configuration: transparent while p_load low, then serial updates
  // parallel path wins over a latch strobe in the same cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      m_r <= CFG_RESET[SR_M_LSB +: M_W];
      n_r <= CFG_RESET[SR_N_LSB +: N_W];
    end else if (!link.p_load || p_load_rise) begin
      m_r <= link.m_sel;
      n_r <= link.n_sel;
    end else if (s_load_fall) begin
      m_r <= shift_r[SR_M_LSB +: M_W];
      n_r <= shift_r[SR_N_LSB +: N_W];
    end
  end

  // probe select has no parallel path
  // a latch fall seen while p_load is low is dropped, not held over
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      t_r <= PROBE_SHIFT;
    end else if (!link.p_load) begin
      t_r <= PROBE_SHIFT;
    end else if (s_load_fall) begin
      t_r <= shift_r[SR_T_LSB +: T_W];
    end
  end

  // vco stand-in counter feeding the post divider
  // in bypass it holds between s_clock edges
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      div_cnt_r <= '0;
    end else if (tick) begin
      div_cnt_r <= div_cnt_r + 4'h1;
    end
  end

  // post divider tap
  always_comb begin
    case (n_r)
      POST_DIV2: synth_nxt = div_cnt_r[1];
      POST_DIV4: synth_nxt = div_cnt_r[2];
      POST_DIV8: synth_nxt = div_cnt_r[3];
      POST_DIV1: synth_nxt = div_cnt_r[0];
      default:   synth_nxt = div_cnt_r[0];
    endcase
  end

  // post output registered so a tap change cannot glitch the pin
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      synth_r <= 1'b0;
    end else begin
      synth_r <= synth_nxt;
    end
  end

  // feedback counter, divides vco by m plus one; a new m is taken at the next reload
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fb_cnt_r <= '0;
    end else if (vco_rise) begin
      fb_cnt_r <= (fb_cnt_r == '0) ? m_r : fb_cnt_r - 9'h001;
    end
  end

  // feedback output: one vco period high per count cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fb_pulse_r <= 1'b0;
    end else if (vco_rise) begin
      fb_pulse_r <= (fb_cnt_r == '0);
    end
  end

  // bypass feedback: high one half period in two post periods, not 50% duty
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      byp_half_r <= 1'b0;
    end else if (synth_rise) begin
      byp_half_r <= ~byp_half_r;
    end
  end

  // reference edge count for the /16 probe tap
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ref_cnt_r <= '0;
    end else if (crystal_reference && !ref_prev_r) begin
      ref_cnt_r <= ref_cnt_r + 4'h1;
    end
  end

  // post output rises for the /4 probe tap
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      syn4_cnt_r <= '0;
    end else if (synth_rise) begin
      syn4_cnt_r <= syn4_cnt_r + 2'h1;
    end
  end

  // probe multiplexer
  always_comb begin
    case (t_r)
      PROBE_SHIFT:  probe_nxt = shift_r[SR_W-1];
      PROBE_ONE:    probe_nxt = 1'b1;
      PROBE_REF16:  probe_nxt = ref_cnt_r[REF_BIT];
      PROBE_FB:     probe_nxt = fb_pulse_r;
      PROBE_SYNTH:  probe_nxt = synth_r;
      PROBE_ZERO:   probe_nxt = 1'b0;
      PROBE_BYPASS: probe_nxt = byp_half_r & synth_r;
      PROBE_SYN4:   probe_nxt = syn4_cnt_r[SYN4_BIT];
      default:      probe_nxt = 1'b0;
    endcase
  end

  // probe pin registered so mux switching cannot glitch it
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      probe_r <= 1'b0;
    end else begin
      probe_r <= probe_nxt;
    end
  end

  assign link.probe_out       = probe_r;
  assign link.synth_clock_out = synth_r;

endmodule

// ---- synth_cfg_pkg.sv ----
// Purpose: shared constants for the divider configuration port and its controller
// Assumes: one 50 MHz core clock, all pins sampled on it
// Notes:
// Operation
// - p_load rise captures parallel m and n
// - p_load low: m and n follow parallel inputs
// - s_clock rise shifts s_data into 14 bits
// - serial load acts only while p_load high
// - stream order: probe, post, feedback fields
// - each field shifted most significant bit first
// - s_load fall moves shifted divides into counters
// - probe select set only by serial stream
// - p_load low forces probe select to zero
// - probe mux decode of eight select codes
// - select 000 streams shift register out
// - select 110 bypasses: s_clock drives dividers
// - bypass probe rate is s_clock over 2N
// - controller streams probe select from cfg unchanged
// - parallel at power-up, serial retune later
// - post select 00:/2 01:/4 10:/8 11:/1
package synth_cfg_pkg;
  localparam int M_W   = 9;
  localparam int N_W   = 2;
  localparam int T_W   = 3;
  localparam int SR_W  = 14;
  localparam int SR_M_LSB = 0;
  localparam int SR_N_LSB = 9;
  localparam int SR_T_LSB = 11;

  localparam logic [T_W-1:0] PROBE_SHIFT  = 3'h0;
  localparam logic [T_W-1:0] PROBE_ONE    = 3'h1;
  localparam logic [T_W-1:0] PROBE_REF16  = 3'h2;
  localparam logic [T_W-1:0] PROBE_FB     = 3'h3;
  localparam logic [T_W-1:0] PROBE_SYNTH  = 3'h4;
  localparam logic [T_W-1:0] PROBE_ZERO   = 3'h5;
  localparam logic [T_W-1:0] PROBE_BYPASS = 3'h6;
  localparam logic [T_W-1:0] PROBE_SYN4   = 3'h7;

  localparam logic [N_W-1:0] POST_DIV2 = 2'h0;
  localparam logic [N_W-1:0] POST_DIV4 = 2'h1;
  localparam logic [N_W-1:0] POST_DIV8 = 2'h2;
  localparam logic [N_W-1:0] POST_DIV1 = 2'h3;

  localparam int DIV_W     = 4;
  localparam int REF_BIT   = 3;
  localparam int SYN4_BIT  = 1;

  localparam int CLK_MHZ       = 50;
  localparam int SCLK_HALF_NS  = 100;
  localparam int PLOAD_LOW_NS  = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int PLOAD_LOW_CYC = (PLOAD_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W         = 8;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CFG    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_PAR_GO = 0;
  localparam int CTRL_SER_GO = 1;
  localparam int ST_BUSY     = 0;
  localparam int ST_PROBE    = 1;
  localparam int ST_SYNTH    = 2;
  localparam int ST_PLOAD    = 3;
  localparam logic [SR_W-1:0] CFG_RESET = 14'h0000;
endpackage

// ---- synth_cfg_if.sv ----
`timescale 1ns/1ps
interface synth_cfg_if;
  import synth_cfg_pkg::*;
  logic           p_load;
  logic [M_W-1:0] m_sel;
  logic [N_W-1:0] n_sel;
  logic           s_clock;
  logic           s_data;
  logic           s_load;
  logic           probe_out;
  logic           synth_clock_out;
  modport device (input p_load, m_sel, n_sel, s_clock, s_data, s_load, output probe_out, synth_clock_out);
  modport ctrl (output p_load, m_sel, n_sel, s_clock, s_data, s_load, input probe_out, synth_clock_out);
endinterface

// ---- synth_cfg_controller.sv ----
`timescale 1ns/1ps
// Purpose: board controller driving the parallel and serial configuration pins
// Assumes: apb slave on core_clk, zero wait states
// Notes: p_load held low from reset until the first parallel load
module synth_cfg_controller
  import synth_cfg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  synth_cfg_if.ctrl        link
);

  typedef enum logic [2:0] {ST_IDLE, ST_PAR, ST_SLOW, ST_SHIGH, ST_LDHI, ST_LDLO} state_t;

  state_t           state_r;
  logic [SR_W-1:0]  cfg_r;
  logic [TMR_W-1:0] tmr_r;
  logic [3:0]       bit_r;
  logic             p_load_r;
  logic             s_clock_r;
  logic             s_data_r;
  logic             s_load_r;
  logic [M_W-1:0]   m_r;
  logic [N_W-1:0]   n_r;
  logic             wr;
  logic             busy;
  logic             tmr_done;
  logic             mapped;

  assign wr       = psel & penable & pwrite;
  assign busy     = (state_r != ST_IDLE);
  assign tmr_done = (tmr_r == '0);
  assign mapped   = (paddr == REG_CTRL) | (paddr == REG_CFG) | (paddr == REG_STATUS);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  always_comb begin
    case (paddr)
      REG_CFG:    prdata = {18'h00000, cfg_r};
      REG_STATUS: prdata = {28'h0000000, p_load_r, link.synth_clock_out, link.probe_out, busy};
      default:    prdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cfg_r <= CFG_RESET;
    end else if (wr && !busy && paddr == REG_CFG) begin
      cfg_r <= pwdata[SR_W-1:0];
    end
  end

  // sequencer; m/n/p_load and serial pins share one state machine
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r   <= ST_IDLE;
      tmr_r     <= '0;
      bit_r     <= '0;
      p_load_r  <= 1'b0;
      s_clock_r <= 1'b0;
      s_data_r  <= 1'b0;
      s_load_r  <= 1'b0;
      m_r       <= CFG_RESET[SR_M_LSB +: M_W];
      n_r       <= CFG_RESET[SR_N_LSB +: N_W];
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wr && paddr == REG_CTRL && pwdata[CTRL_PAR_GO]) begin
            m_r      <= cfg_r[SR_M_LSB +: M_W];
            n_r      <= cfg_r[SR_N_LSB +: N_W];
            p_load_r <= 1'b0;
            tmr_r    <= TMR_W'(PLOAD_LOW_CYC - 1);
            state_r  <= ST_PAR;
          end else if (wr && paddr == REG_CTRL && pwdata[CTRL_SER_GO] && p_load_r) begin
            bit_r    <= 4'(SR_W - 1);
            s_data_r <= cfg_r[SR_W-1];
            tmr_r    <= TMR_W'(SCLK_HALF_CYC - 1);
            state_r  <= ST_SLOW;
          end
        end
        ST_PAR: begin
          if (tmr_done) begin
            p_load_r <= 1'b1;
            state_r  <= ST_IDLE;
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
        ST_SLOW: begin
          if (tmr_done) begin
            s_clock_r <= 1'b1;
            tmr_r     <= TMR_W'(SCLK_HALF_CYC - 1);
            state_r   <= ST_SHIGH;
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
        ST_SHIGH: begin
          if (tmr_done) begin
            s_clock_r <= 1'b0;
            tmr_r     <= TMR_W'(SCLK_HALF_CYC - 1);
            if (bit_r == '0) begin
              s_load_r <= 1'b1;
              state_r  <= ST_LDHI;
            end else begin
              bit_r    <= bit_r - 4'h1;
              s_data_r <= cfg_r[bit_r - 4'h1];
              state_r  <= ST_SLOW;
            end
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
        ST_LDHI: begin
          if (tmr_done) begin
            s_load_r <= 1'b0;
            tmr_r    <= TMR_W'(SCLK_HALF_CYC - 1);
            state_r  <= ST_LDLO;
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
        ST_LDLO: begin
          if (tmr_done) begin
            state_r <= ST_IDLE;
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign link.p_load  = p_load_r;
  assign link.m_sel   = m_r;
  assign link.n_sel   = n_r;
  assign link.s_clock = s_clock_r;
  assign link.s_data  = s_data_r;
  assign link.s_load  = s_load_r;

endmodule

// ---- synth_link_props.sv ----
// Purpose: timing checks on the configuration link pins
// Assumes: shift half period and latch pulse 5 core cycles each, parallel low 10
// Notes: one core_clk domain
`timescale 1ns/1ps
module synth_link_props
  import synth_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic p_load,
  input wire logic s_clock,
  input wire logic s_data,
  input wire logic s_load
);
  logic       sc_q_r;
  logic [4:0] bits_r;

  always_ff @(posedge core_clk) begin
    sc_q_r <= s_clock;
  end

  // rising shift clocks seen since the last latch pulse
  always_ff @(posedge core_clk) begin
    if (!resetn || s_load) begin
      bits_r <= 5'h00;
    end else if (s_clock && !sc_q_r) begin
      bits_r <= bits_r + 5'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence sclk_hi;
    s_clock[*5] ##1 !s_clock;
  endsequence

  sequence load_pulse;
    s_load[*5] ##1 !s_load;
  endsequence

  AST_SCLK_HIGH: assert property ($rose(s_clock) |-> sclk_hi)
    else $error("shift clock high phase wrong");
  AST_SCLK_LOW: assert property ($fell(s_clock) |-> !s_clock[*5])
    else $error("shift clock low phase short");
  AST_SDATA_HOLD: assert property (s_clock |-> $stable(s_data))
    else $error("serial data moved while clock high");
  AST_FRAME_BITS: assert property ($rose(s_load) |-> bits_r == 5'h0e)
    else $error("latch pulse not after 14 bits");
  AST_SLOAD_PULSE: assert property ($rose(s_load) |-> load_pulse)
    else $error("latch pulse width wrong");
  AST_SLOAD_AFTER: assert property ($rose(s_load) |-> $past(s_clock) && !s_clock)
    else $error("latch pulse not after last clock");
  AST_SER_GATED: assert property (!p_load |-> !s_clock && !s_load)
    else $error("serial activity while parallel strobe low");
  AST_PLOAD_LOW: assert property ($fell(p_load) |-> !p_load[*8] ##[1:4] p_load)
    else $error("parallel strobe low time wrong");
endmodule

// ---- tb_synth_divider_config_port.sv ----
// Purpose: apb driven test of both link ends
// Assumes: expectations from cfg fields and package constants
// Notes: reference toggles every 2 core cycles
`timescale 1ns/1ps
module tb_synth_divider_config_port;
  import synth_cfg_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn;
  logic [1:0]  ref_cnt = 2'h0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  logic [13:0] cap_r = 14'h0;
  logic [13:0] pcap = 14'h0;
  logic        sc_q = 1'b0;
  logic        syn_q = 1'b0;
  logic        prb_q = 1'b0;
  int          syn_tg = 0;
  int          prb_tg = 0;
  int          fails;
  int          check_count;
  int          h;
  int          s0;
  int          p0;
  int          hp[4] = '{2, 4, 8, 1};
  int          ph[6] = '{0, 0, 1, 4, 32, 0};
  logic [2:0]  tv[6] = '{3'h1, 3'h5, 3'h4, 3'h7, 3'h2, 3'h3};

  synth_cfg_if lnk ();

  synth_divider_config_port synth_divider_config_port_inst (
    .core_clk          (core_clk),
    .resetn            (resetn),
    .crystal_reference (ref_cnt[1]),
    .link              (lnk)
  );

  synth_cfg_controller synth_cfg_controller_inst (
    .core_clk (core_clk),
    .resetn   (resetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .link     (lnk)
  );

  synth_link_props synth_link_props_inst (
    .core_clk (core_clk),
    .resetn   (resetn),
    .p_load   (lnk.p_load),
    .s_clock  (lnk.s_clock),
    .s_data   (lnk.s_data),
    .s_load   (lnk.s_load)
  );

  always #10 core_clk = ~core_clk;

  // monitor: shifted bits and output toggles
  always @(posedge core_clk) begin
    ref_cnt <= ref_cnt + 2'h1;
    sc_q <= lnk.s_clock;
    syn_q <= lnk.synth_clock_out;
    prb_q <= lnk.probe_out;
    if (lnk.s_clock && !sc_q) begin
      cap_r <= {cap_r[12:0], lnk.s_data};
      pcap <= {pcap[12:0], lnk.probe_out};
    end
    if (lnk.synth_clock_out !== syn_q) begin
      syn_tg++;
    end
    if (lnk.probe_out !== prb_q) begin
      prb_tg++;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp=%h seen=%h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never reassigns psel in this time step
    @(posedge core_clk);
  endtask

  task automatic idle();
    do apb(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY] !== 1'b0);
  endtask

  task automatic par(input logic [13:0] c);
    apb(1'b1, REG_CFG, {18'h0, c});
    apb(1'b1, REG_CTRL, 32'h1);
    idle();
  endtask

  task automatic ser(input logic [13:0] c);
    apb(1'b1, REG_CFG, {18'h0, c});
    apb(1'b1, REG_CTRL, 32'h2);
    idle();
    check("stream", {18'h0, cap_r}, {18'h0, c});
  endtask

  function automatic logic pick(input logic sel);
    return sel ? lnk.probe_out : lnk.synth_clock_out;
  endfunction

  // second pass gives the half period, 300 means static
  task automatic half(input logic sel, output int n);
    logic v;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      v = pick(sel);
      while (pick(sel) === v && n < 300) begin
        @(negedge core_clk);
        n++;
      end
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    final_report();
  end

  initial begin
    fails = 0;
    check_count = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    apb(1'b1, REG_CTRL, 32'h2);
    apb(1'b0, REG_STATUS, 32'h0);
    check("busy", 32'(rd[ST_BUSY]), 32'h0);
    check("pload", 32'(rd[ST_PLOAD]), 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped_err", 32'(err), 32'h1);
    check("unmapped_rd", rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      par({3'h0, 2'(i), 9'h0a5});
      half(1'b0, h);
      check("synth_half", 32'(h), 32'(hp[i]));
    end
    apb(1'b0, REG_CFG, 32'h0);
    check("cfg_rd", rd, 32'h06a5);
    apb(1'b0, REG_STATUS, 32'h0);
    check("pload_hi", 32'(rd[ST_PLOAD]), 32'h1);
    $display("test parallel done");
    for (int i = 0; i < 6; i++) begin
      ser({tv[i], 2'h3, 9'h003});
      half(1'b1, h);
      if (i < 2) begin
        check("probe_lvl", 32'(lnk.probe_out), 32'(i == 0));
      end else if (i < 5) begin
        check("probe_half", 32'(h), 32'(ph[i]));
      end else begin
        // m of 3: high one vco period, low three
        check("fb_half", 32'(h == 2 || h == 6), 32'h1);
      end
    end
    $display("test probe codes done");
    ser(14'h0800);
    check("probe_one", 32'(lnk.probe_out), 32'h1);
    par(14'h38a5);
    check("probe_forced", 32'(lnk.probe_out), 32'h0);
    half(1'b1, h);
    check("probe_static", 32'(h), 32'd300);
    $display("test probe reset done");
    ser({3'h6, 2'h3, 9'h003});
    // select was 000 through this frame, so the probe streamed the old contents
    check("shift_out", {18'h0, pcap}, 32'h00000800);
    half(1'b0, h);
    check("byp_still", 32'(h), 32'd300);
    s0 = syn_tg;
    p0 = prb_tg;
    ser({3'h6, 2'h3, 9'h003});
    check("byp_synth", 32'(syn_tg - s0), 32'd28);
    check("byp_probe", 32'(prb_tg - p0 >= 13 && prb_tg - p0 <= 15), 32'h1);
    $display("test bypass done");
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, REG_CFG, 32'h0);
    check("rst_cfg", rd, {18'h0, CFG_RESET});
    apb(1'b0, REG_STATUS, 32'h0);
    check("rst_pload", 32'(rd[ST_PLOAD]), 32'h0);
    check("rst_probe", 32'(rd[ST_PROBE]), 32'h0);
    $display("test mid reset done");
    final_report();
  end
endmodule
